/* File: hw/rr_exec_pkg.sv */
// Shared types and constants for the return and rotate execution block
// =====================================================================
// Functional notes
// - Return from interrupt pops the stack and loads the program counter from the top entry.
// - Return from interrupt also sets the global interrupt enable, bit 7 of the control reg.
// - Return from interrupt is one program word and takes two instruction cycles.
// - Return with literal loads the working register with its 8-bit operand, 0 to 255.
// - Return with literal loads the program counter from the top of stack in two cycles.
// - Return from subroutine pops the stack, loads the program counter, in two cycles.
// - Rotate left moves old carry into bit 0 and old bit 7 into the carry.
// - Rotate destination 0 writes the working register, 1 writes the file register.
// - Rotate right shifts through carry with the same destination choice as rotate left.
package rr_exec_pkg;

   // ==================================================================
   // Widths, positions and counts
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned FADDR_W       = 7;
   localparam int unsigned GIE_BIT       = 7;
   localparam int unsigned RET_CYCLES    = 2;
   localparam int unsigned ROT_CYCLES    = 1;
   localparam logic        DEST_W_REG    = 1'b0;
   localparam logic        DEST_FILE_REG = 1'b1;
   localparam logic [7:0]  DATA_RST      = 8'h00;
   localparam logic [6:0]  FADDR_RST     = 7'h00;

   // ==================================================================
   // Operation classes handed over by the decoder
   typedef enum logic [2:0] {
      OP_NONE,
      OP_RETURN_FROM_INTERRUPT,
      OP_RETURN_WITH_LITERAL,
      OP_RETURN_SUB,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY
   } op_t;

   typedef struct packed {
      op_t               op;
      logic [7:0]        literal;
      logic [6:0]        faddr;
      logic              dest;
   } instr_t;

endpackage : rr_exec_pkg

/* File: hw/rotate_carry_unit.sv */
// One-bit rotate through carry, left or right
`timescale 1ns/1ns
`default_nettype none
module rotate_carry_unit #(
   parameter int unsigned W = 8
) (
   // Operand
   input  wire logic [W-1:0] data_i,
   input  wire logic         carry_i,
   input  wire logic         right_i,
   // Result
   output logic      [W-1:0] result_o,
   output logic              carry_o
);

   // ==================================================================
   // Rotation
   always_comb begin
      if (right_i) begin
         result_o = {carry_i, data_i[W-1:1]};
         carry_o  = data_i[0];
      end else begin
         result_o = {data_i[W-2:0], carry_i};
         carry_o  = data_i[W-1];
      end
   end

endmodule : rotate_carry_unit
`default_nettype wire

/* File: hw/return_and_rotate_exec.sv */
// Execution of the return and rotate-through-carry instructions
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec #(
   parameter int unsigned PC_W = 15
) (
   // Clock and reset
   input  wire logic                        REF_CLK_I,
   input  wire logic                        RST_N_I,
   // Instruction issue
   input  wire logic                        ISSUE_I,
   input  wire rr_exec_pkg::instr_t         INSTR_I,
   output logic                             READY_O,
   output logic                             DONE_O,
   // Core state read in the issue cycle
   input  wire logic [PC_W-1:0]             TOS_I,
   input  wire logic [7:0]                  FILE_RDATA_I,
   input  wire logic                        CARRY_I,
   // Stack and program counter
   output logic                             STACK_POP_O,
   output logic                             PC_LOAD_O,
   output logic      [PC_W-1:0]             PC_O,
   // Working and file register writes
   output logic                             W_WE_O,
   output logic      [7:0]                  W_DATA_O,
   output logic                             FILE_WE_O,
   output logic      [6:0]                  FILE_ADDR_O,
   output logic      [7:0]                  FILE_WDATA_O,
   // Status and interrupt control
   output logic                             CARRY_WE_O,
   output logic                             CARRY_O,
   output logic                             GIE_SET_O,
   output logic      [7:0]                  INTERRUPT_CONTROL_REG_SET_MASK_O
);

   // ==================================================================
   // State
   typedef enum logic {
      ST_IDLE,
      ST_FLUSH
   } fsm_t;

   typedef struct packed {
      fsm_t              fsm;
      logic              done;
      logic              pop;
      logic              pc_load;
      logic [PC_W-1:0]   pc;
      logic              w_we;
      logic [7:0]        w_data;
      logic              f_we;
      logic [6:0]        f_addr;
      logic [7:0]        f_data;
      logic              c_we;
      logic              c_data;
      logic              gie_set;
   } state_t;

   localparam state_t STATE_RST = '{
      fsm:     ST_IDLE,
      done:    1'b0,
      pop:     1'b0,
      pc_load: 1'b0,
      pc:      '0,
      w_we:    1'b0,
      w_data:  rr_exec_pkg::DATA_RST,
      f_we:    1'b0,
      f_addr:  rr_exec_pkg::FADDR_RST,
      f_data:  rr_exec_pkg::DATA_RST,
      c_we:    1'b0,
      c_data:  1'b0,
      gie_set: 1'b0
   };

   state_t q;
   state_t d;
   logic   take;
   logic   is_ret;
   logic   is_rot;
   logic   rot_right;
   logic [7:0] rot_res;
   logic   rot_c;

   assign take      = ISSUE_I && (q.fsm == ST_IDLE);
   assign is_ret    = (INSTR_I.op == rr_exec_pkg::OP_RETURN_FROM_INTERRUPT) ||
                      (INSTR_I.op == rr_exec_pkg::OP_RETURN_WITH_LITERAL) ||
                      (INSTR_I.op == rr_exec_pkg::OP_RETURN_SUB);
   assign rot_right = (INSTR_I.op == rr_exec_pkg::OP_ROTATE_RIGHT_CARRY);
   assign is_rot    = rot_right || (INSTR_I.op == rr_exec_pkg::OP_ROTATE_LEFT_CARRY);

   rotate_carry_unit #(
      .W        (rr_exec_pkg::DATA_W)
   ) u_rot (
      .data_i   (FILE_RDATA_I),
      .carry_i  (CARRY_I),
      .right_i  (rot_right),
      .result_o (rot_res),
      .carry_o  (rot_c)
   );

   // ==================================================================
   // Next state
   always_comb begin
      d         = q;
      d.done    = 1'b0;
      d.pop     = 1'b0;
      d.pc_load = 1'b0;
      d.w_we    = 1'b0;
      d.f_we    = 1'b0;
      d.c_we    = 1'b0;
      d.gie_set = 1'b0;
      case (q.fsm)
         ST_IDLE: begin
            if (take && is_ret) begin
               // Second cycle is spent flushing the fetched word
               d.fsm     = ST_FLUSH;
               d.pop     = 1'b1;
               d.pc_load = 1'b1;
               d.pc      = TOS_I;
               d.done    = 1'b1;
               // No carry write on any return
               d.c_we    = 1'b0;
               if (INSTR_I.op == rr_exec_pkg::OP_RETURN_FROM_INTERRUPT) begin
                  d.gie_set = 1'b1;
               end
               if (INSTR_I.op == rr_exec_pkg::OP_RETURN_WITH_LITERAL) begin
                  d.w_we   = 1'b1;
                  d.w_data = INSTR_I.literal;
               end
            end else if (take && is_rot) begin
               // Stays ready: single cycle, carry is the only flag touched
               d.done   = 1'b1;
               d.c_we   = 1'b1;
               d.c_data = rot_c;
               d.f_addr = INSTR_I.faddr;
               if (INSTR_I.dest == rr_exec_pkg::DEST_FILE_REG) begin
                  d.f_we   = 1'b1;
                  d.f_data = rot_res;
               end else begin
                  d.w_we   = 1'b1;
                  d.w_data = rot_res;
               end
            end
         end
         ST_FLUSH: begin
            d.fsm = ST_IDLE;
         end
         default: begin
            d.fsm = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q <= STATE_RST;
      end else begin
         q <= d;
      end
   end

   // ==================================================================
   // Outputs
   assign READY_O           = (q.fsm == ST_IDLE);
   assign DONE_O            = q.done;
   assign STACK_POP_O       = q.pop;
   assign PC_LOAD_O         = q.pc_load;
   assign PC_O              = q.pc;
   assign W_WE_O            = q.w_we;
   assign W_DATA_O          = q.w_data;
   assign FILE_WE_O         = q.f_we;
   assign FILE_ADDR_O       = q.f_addr;
   assign FILE_WDATA_O      = q.f_data;
   assign CARRY_WE_O        = q.c_we;
   assign CARRY_O           = q.c_data;
   assign GIE_SET_O         = q.gie_set;
   assign INTERRUPT_CONTROL_REG_SET_MASK_O = 8'(q.gie_set) << rr_exec_pkg::GIE_BIT;

   // ==================================================================
   // Checks
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   logic ret_take;
   logic rot_take;
   assign ret_take = take && is_ret;
   assign rot_take = take && is_rot;

   property p_ret_pop_pc;
      ret_take |=> STACK_POP_O && PC_LOAD_O && (PC_O == $past(TOS_I));
   endproperty
   a_ret_pop_pc: assert property (p_ret_pop_pc) else $error("return did not load pc");

   property p_gie_set;
      GIE_SET_O |-> $past(take && INSTR_I.op == rr_exec_pkg::OP_RETURN_FROM_INTERRUPT)
                    && INTERRUPT_CONTROL_REG_SET_MASK_O == 8'h80;
   endproperty
   a_gie_set: assert property (p_gie_set) else $error("global enable set wrongly");

   property p_ret_two_cycles;
      ret_take |=> !READY_O ##1 READY_O;
   endproperty
   a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("return not 2 cycles");

   property p_return_with_literal_op_w;
      take && INSTR_I.op == rr_exec_pkg::OP_RETURN_WITH_LITERAL
         |=> W_WE_O && (W_DATA_O == $past(INSTR_I.literal)) && !FILE_WE_O;
   endproperty
   a_return_with_literal_op_w: assert property (p_return_with_literal_op_w) else $error("literal not loaded to w");

   property p_return_with_literal_op_pc;
      take && INSTR_I.op == rr_exec_pkg::OP_RETURN_WITH_LITERAL
         |=> PC_LOAD_O && (PC_O == $past(TOS_I)) ##1 !PC_LOAD_O;
   endproperty
   a_return_with_literal_op_pc: assert property (p_return_with_literal_op_pc) else $error("literal return pc wrong");

   property p_return_sub;
      take && INSTR_I.op == rr_exec_pkg::OP_RETURN_SUB
         |=> STACK_POP_O && !W_WE_O && !GIE_SET_O ##1 READY_O && !STACK_POP_O;
   endproperty
   a_return_sub: assert property (p_return_sub) else $error("subroutine return wrong");

   property p_rlf;
      take && INSTR_I.op == rr_exec_pkg::OP_ROTATE_LEFT_CARRY
         |=> CARRY_WE_O && (CARRY_O == $past(FILE_RDATA_I[7]))
             && ((W_WE_O ? W_DATA_O : FILE_WDATA_O)
                 == {$past(FILE_RDATA_I[6:0]), $past(CARRY_I)});
   endproperty
   a_rlf: assert property (p_rlf) else $error("rotate left value wrong");

   property p_dest;
      rot_take |=> (FILE_WE_O == $past(INSTR_I.dest)) && (W_WE_O != $past(INSTR_I.dest))
                   && (!FILE_WE_O || FILE_ADDR_O == $past(INSTR_I.faddr));
   endproperty
   a_dest: assert property (p_dest) else $error("rotate destination wrong");

   property p_rrf;
      take && INSTR_I.op == rr_exec_pkg::OP_ROTATE_RIGHT_CARRY
         |=> (CARRY_O == $past(FILE_RDATA_I[0]))
             && ((W_WE_O ? W_DATA_O : FILE_WDATA_O)
                 == {$past(CARRY_I), $past(FILE_RDATA_I[7:1])});
   endproperty
   a_rrf: assert property (p_rrf) else $error("rotate right value wrong");

   property p_flags;
      (ret_take |=> !CARRY_WE_O) and (rot_take |=> READY_O && !STACK_POP_O && !PC_LOAD_O);
   endproperty
   a_flags: assert property (p_flags) else $error("flag or timing side effect");

   c_return_from_interrupt_op: cover property (take && INSTR_I.op == rr_exec_pkg::OP_RETURN_FROM_INTERRUPT);
   c_return_with_literal_op:  cover property (take && INSTR_I.op == rr_exec_pkg::OP_RETURN_WITH_LITERAL);
   c_rot_bb: cover property (rot_take ##1 rot_take);
   c_rot_f:  cover property (rot_take && INSTR_I.dest == rr_exec_pkg::DEST_FILE_REG);

endmodule : return_and_rotate_exec
`default_nettype wire

/* File: hw/unused_placeholder_removed.sv */
// Intentionally minimal: no logic in this file
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: verif/return_and_rotate_exec_bench.sv */
// Self-checking bench for the return and rotate execution block
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_exec_bench;

   // =====================================================================
   // Signals
   localparam int unsigned PCW = 15;
   logic                clk   = 1'b0;
   logic                rst_n = 1'b0;
   logic                issue = 1'b0;
   rr_exec_pkg::instr_t instr = '0;
   logic [PCW-1:0]      top_of_stack   = '0;
   logic [7:0]          fdat  = 8'h00;
   logic                cin   = 1'b0;
   logic                ready, done, pop, pc_load, w_we, f_we, c_we, c_out, global_irq_enable;
   logic [PCW-1:0]      pc;
   logic [7:0]          w_data, f_wdata, gmask;
   logic [6:0]          f_addr;
   logic [53:0]         exp_q[$];
   logic [53:0]         care_q[$];
   logic [31:0]         seed = 32'hc3708419;
   int                  miscompares = 0;
   int                  check_count = 0;
   rr_exec_pkg::op_t    ops[5] = '{rr_exec_pkg::OP_RETURN_FROM_INTERRUPT,
      rr_exec_pkg::OP_RETURN_WITH_LITERAL, rr_exec_pkg::OP_RETURN_SUB,
      rr_exec_pkg::OP_ROTATE_LEFT_CARRY, rr_exec_pkg::OP_ROTATE_RIGHT_CARRY};

   always #5 clk = ~clk;

   return_and_rotate_exec #(.PC_W(PCW)) dut (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .ISSUE_I(issue), .INSTR_I(instr),
      .READY_O(ready), .DONE_O(done), .TOS_I(top_of_stack), .FILE_RDATA_I(fdat),
      .CARRY_I(cin), .STACK_POP_O(pop), .PC_LOAD_O(pc_load), .PC_O(pc),
      .W_WE_O(w_we), .W_DATA_O(w_data), .FILE_WE_O(f_we), .FILE_ADDR_O(f_addr),
      .FILE_WDATA_O(f_wdata), .CARRY_WE_O(c_we), .CARRY_O(c_out),
      .GIE_SET_O(global_irq_enable), .INTERRUPT_CONTROL_REG_SET_MASK_O(gmask));

   // =====================================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic check(input string name, input logic [53:0] e, input logic [53:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   // Drives one issue and notes its expected result; a return is followed by an
   // issue in the flush cycle, which must be ignored
   task automatic send(input rr_exec_pkg::op_t op, input logic [7:0] lit,
                       input logic [7:0] fd, input logic c, input logic d);
      logic [31:0] r;
      logic [7:0]  res;
      logic [53:0] e, m;
      logic        rot, left, rfi, rwl;
      r    = rnd();
      rfi  = (op == rr_exec_pkg::OP_RETURN_FROM_INTERRUPT);
      rwl  = (op == rr_exec_pkg::OP_RETURN_WITH_LITERAL);
      left = (op == rr_exec_pkg::OP_ROTATE_LEFT_CARRY);
      rot  = left || (op == rr_exec_pkg::OP_ROTATE_RIGHT_CARRY);
      res  = left ? {fd[6:0], c} : {c, fd[7:1]};
      @(posedge clk);
      issue <= 1'b1;
      instr <= '{op, lit, r[6:0], d};
      top_of_stack   <= r[21:7];
      fdat  <= fd;
      cin   <= c;
      if (!rot) begin
         e = {3'b011, r[21:7], rfi, rfi ? 8'h80 : 8'h00, rwl, lit, 16'h0000, 2'b00};
         m = {18'h3ffff, 9'h1ff, 1'b1, {8{rwl}}, 16'h8000, 2'b10};
      end else begin
         e = {3'b100, 15'h0000, 9'h000, ~d, res, d, r[6:0], res, 1'b1,
              left ? fd[7] : fd[0]};
         m = {3'b111, 15'h0000, 9'h1ff, 1'b1, {8{~d}}, 1'b1, {15{d}}, 2'b11};
      end
      exp_q.push_back(e);
      care_q.push_back(m);
      if (!rot) begin
         @(posedge clk);
         instr <= '{rr_exec_pkg::OP_ROTATE_LEFT_CARRY, lit, r[6:0], d};
      end
   endtask : send

   // =====================================================================
   // Result watcher: every done pulse must match the oldest note
   always @(negedge clk) begin
      if (rst_n && done !== 1'b0) begin
         if (exp_q.size() == 0)
            check("unexpected done", 54'h0, 54'h1);
         else
            check("exec outputs", exp_q[0] & care_q[0],
                  {ready, pop, pc_load, pc, global_irq_enable, gmask, w_we, w_data, f_we, f_addr,
                   f_wdata, c_we, c_out} & care_q[0]);
         if (exp_q.size() != 0) begin
            void'(exp_q.pop_front());
            void'(care_q.pop_front());
         end
      end
   end

   // =====================================================================
   // Stimulus
   initial begin
      logic [31:0] r;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check("reset state", 54'({ready, done, pc, w_data, c_out}), 54'h1 << 25);
      send(rr_exec_pkg::OP_ROTATE_LEFT_CARRY, 8'h00, 8'he6, 1'b0, 1'b0);
      // Returns, rotates after returns and rotates back to back, both destinations
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         send(ops[i % 5], (i == 1) ? 8'h00 : (i == 6) ? 8'hff : r[7:0],
              r[15:8], r[16], i[0]);
      end
      @(posedge clk);
      issue <= 1'b0;
      repeat (4) @(posedge clk);
      check("pending results", 54'h0, 54'(exp_q.size()));
      test_done();
   end

   // Limit well above the roughly 106 cycles the sequence needs
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      test_done();
   end

endmodule : return_and_rotate_exec_bench
`default_nettype wire
